/* src/fmrc_top.sv */
// Mode and reset command control of a serial flash: wrap setting,
// software reset, continuous read mode and deep power-down.
// Assumes CS stays high at least 4 core clocks between frames and that
// SCK stands still while CS is high.
module fmrc_top
  import fmrc_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic [3:0]        io_in,
  input  wire logic              rd_load,
  input  wire logic [ADDR_W-1:0] rd_load_addr,
  input  wire logic              rd_next,
  input  wire logic              rd_quad_io,
  output logic      [2:0]        wrap_field,
  output logic                   continuous_read,
  output logic                   deep_power_down,
  output logic                   soft_reset,
  output logic                   busy,
  output logic      [ADDR_W-1:0] rd_addr
);
  localparam int A_DP_MAX  = T_DP_CYC + 2;
  localparam int A_REL_MAX = T_RES1_CYC + 2;

  // Link side, clocked by SCK
  fmrc_frame_t l_frm_reg;
  fmrc_frame_t l_frm_next;
  logic        l_first_reg;
  logic        l_clr;
  logic        l_ftgl_reg;
  logic        l_ftgl_next;
  logic        l_btgl_reg;
  logic        l_btgl_next;
  logic [5:0]  l_idx;
  logic [5:0]  l_base;

  // Core side
  fmrc_state_t       st_reg;
  fmrc_state_t       st_next;
  logic [TMR_W-1:0]  tmr_reg;
  logic [TMR_W-1:0]  tmr_next;
  logic [2:0]        wrap_field_reg;
  logic [2:0]        wrap_field_next;
  logic              cont_reg;
  logic              cont_next;
  logic              cont_quad_reg;
  logic              cont_quad_next;
  logic              rst_en_reg;
  logic              rst_en_next;
  logic              soft_reset_reg;
  logic              soft_reset_next;
  logic              busy_reg;
  logic              busy_next;
  logic              pdn_reg;
  logic              pdn_next;
  logic              cs_prev_reg;
  logic              cs_prev_next;
  logic              fseen_reg;
  logic              fseen_next;
  logic              bseen_reg;
  logic              bseen_next;
  logic [HOLD_W-1:0] hold_cnt_reg;
  logic [HOLD_W-1:0] hold_cnt_next;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [ADDR_W-1:0] rd_addr_next;
  logic [ADDR_W-1:0] step_addr;
  logic [2:0]        sync_q;
  fmrc_frame_t       f;
  logic              frame_go;
  logic              hold_ok;
  logic [5:0]        mode_pos;
  logic              mode_done;
  logic              mode_skip;
  logic [2:0]        f_wrap;

  assign l_clr = cs_n | ~rstn;

  // Frame start marker; cleared by the first SCK edge of each frame
  always_ff @(posedge sclk or posedge l_clr) begin
    if (l_clr) begin
      l_first_reg <= 1'b1;
    end else begin
      l_first_reg <= 1'b0;
    end
  end

  always_comb begin
    l_frm_next = l_frm_reg;
    l_idx      = l_first_reg ? 6'h00 : l_frm_reg.cnt;
    if (l_first_reg) begin
      // Core only changes these while CS is high
      l_frm_next.cont = cont_reg;
      l_frm_next.op   = cont_quad_reg ? OP_QIO : OP_DIO;
      l_frm_next.cnt  = 6'h01;
    end else if (l_frm_reg.cnt != CNT_SAT) begin
      l_frm_next.cnt = l_frm_reg.cnt + 6'h01;
    end
    l_base = l_frm_next.cont ? 6'h00 : CNT_OP;
    if (!l_frm_next.cont && l_idx < CNT_OP) begin
      l_frm_next.op = {l_frm_next.op[6:0], io_in[0]};
    end
    if (l_idx == l_base + POS_QUAD &&
        (l_frm_next.op == OP_QIO || l_frm_next.op == OP_WRAP)) begin
      l_frm_next.mode = io_in[1:0];
      l_frm_next.wrap = io_in[2:0];
    end
    if (l_idx == l_base + POS_DUAL && l_frm_next.op == OP_DIO) begin
      l_frm_next.mode = io_in[1:0];
    end
    l_ftgl_next = l_ftgl_reg ^ l_first_reg;
    l_btgl_next = l_btgl_reg ^ (!l_frm_next.cont && l_idx == CNT_OP - 6'h01);
  end

  // Results are held after the frame so the core can read them
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      l_frm_reg  <= '0;
      l_ftgl_reg <= 1'b0;
      l_btgl_reg <= 1'b0;
    end else begin
      l_frm_reg  <= l_frm_next;
      l_ftgl_reg <= l_ftgl_next;
      l_btgl_reg <= l_btgl_next;
    end
  end

  fmrc_sync #(
    .W       (3),
    .RST_VAL (3'h4)
  ) u_sync (
    .clk  (core_clk),
    .rstn (rstn),
    .ce   (ce),
    .d    ({cs_n, l_ftgl_reg, l_btgl_reg}),
    .q    (sync_q)
  );

  fmrc_wrap_step #(
    .ADDR_W (ADDR_W)
  ) u_step (
    .addr      (rd_addr_reg),
    .wrap      (wrap_field_reg),
    .en        (rd_quad_io),
    .next_addr (step_addr)
  );

  // Frame fields are stable once the synchronised CS shows high
  assign f        = l_frm_reg;
  assign f_wrap   = f.wrap;
  assign frame_go = ce && sync_q[2] && !cs_prev_reg && (sync_q[1] != fseen_reg);
  assign hold_ok  = hold_cnt_reg >= HOLD_W'(T_RCH_CYC);
  assign mode_pos = (f.cont ? 6'h00 : CNT_OP) +
                    (f.op == OP_DIO ? POS_DUAL : POS_QUAD);
  assign mode_done = (f.op == OP_QIO || f.op == OP_DIO) && f.cnt > mode_pos;
  assign mode_skip = f.mode == SKIP_CODE;

  always_comb begin
    st_next         = st_reg;
    tmr_next        = tmr_reg;
    wrap_field_next = wrap_field_reg;
    cont_next       = cont_reg;
    cont_quad_next  = cont_quad_reg;
    rst_en_next     = rst_en_reg;
    soft_reset_next = 1'b0;
    cs_prev_next    = ce ? sync_q[2] : cs_prev_reg;
    // Parity frozen while CS is low, so a frame with SCK edges shows a change
    fseen_next      = (ce && sync_q[2]) ? sync_q[1] : fseen_reg;
    bseen_next      = ce ? sync_q[0] : bseen_reg;
    hold_cnt_next   = hold_cnt_reg;
    if (ce) begin
      // Hold delay counts from the end of each opcode byte
      if (sync_q[0] != bseen_reg) begin
        hold_cnt_next = '0;
      end else if (hold_cnt_reg != '1) begin
        hold_cnt_next = hold_cnt_reg + 1'b1;
      end
      if (tmr_reg != '0) begin
        tmr_next = tmr_reg - 1'b1;
      end
    end
    case (st_reg)
      ST_IDLE: begin
        if (frame_go) begin
          rst_en_next = 1'b0;
          if (mode_done) begin
            cont_next      = mode_skip;
            cont_quad_next = f.op == OP_QIO;
          end
          if (!f.cont) begin
            case (f.op)
              OP_WRAP: begin
                if (f.cnt >= CNT_WRAP_MIN) begin
                  wrap_field_next = f.wrap;
                end
              end
              OP_RST_EN: begin
                rst_en_next = f.cnt == CNT_OP;
              end
              OP_RST: begin
                // Executes only at CS rise, after the hold delay
                if (f.cnt == CNT_OP && rst_en_reg && hold_ok) begin
                  wrap_field_next = WRAP_DEFAULT;
                  cont_next       = 1'b0;
                  cont_quad_next  = 1'b0;
                  soft_reset_next = 1'b1;
                  tmr_next        = TMR_W'(T_RST_CYC);
                  st_next         = ST_RST;
                end
              end
              OP_PDN: begin
                if (f.cnt == CNT_OP) begin
                  tmr_next = TMR_W'(T_DP_CYC);
                  st_next  = ST_PDN_ENT;
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
      ST_PDN_ENT: begin
        if (ce && tmr_reg == '0) begin
          st_next = ST_PDN;
        end
      end
      ST_PDN: begin
        // Everything but release is dropped, resets included
        if (frame_go && !f.cont && f.op == OP_REL && f.cnt >= CNT_OP) begin
          tmr_next = TMR_W'(T_RES1_CYC);
          st_next  = ST_REL;
        end
      end
      ST_REL, ST_RST: begin
        if (ce && tmr_reg == '0) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
    busy_next = st_next != ST_IDLE;
    pdn_next  = st_next == ST_PDN;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg         <= ST_IDLE;
      tmr_reg        <= '0;
      wrap_field_reg <= WRAP_DEFAULT;
      cont_reg       <= 1'b0;
      cont_quad_reg  <= 1'b0;
      rst_en_reg     <= 1'b0;
      soft_reset_reg <= 1'b0;
      busy_reg       <= 1'b0;
      pdn_reg        <= 1'b0;
      cs_prev_reg    <= 1'b1;
      fseen_reg      <= 1'b0;
      bseen_reg      <= 1'b0;
      hold_cnt_reg   <= '0;
    end else begin
      st_reg         <= st_next;
      tmr_reg        <= tmr_next;
      wrap_field_reg <= wrap_field_next;
      cont_reg       <= cont_next;
      cont_quad_reg  <= cont_quad_next;
      rst_en_reg     <= rst_en_next;
      soft_reset_reg <= soft_reset_next;
      busy_reg       <= busy_next;
      pdn_reg        <= pdn_next;
      cs_prev_reg    <= cs_prev_next;
      fseen_reg      <= fseen_next;
      bseen_reg      <= bseen_next;
      hold_cnt_reg   <= hold_cnt_next;
    end
  end

  // Read address sequencer for the read datapath
  always_comb begin
    rd_addr_next = rd_addr_reg;
    if (ce && rd_load) begin
      rd_addr_next = rd_load_addr;
    end else if (ce && rd_next) begin
      rd_addr_next = step_addr;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_addr_reg <= '0;
    end else begin
      rd_addr_reg <= rd_addr_next;
    end
  end

  assign wrap_field      = wrap_field_reg;
  assign continuous_read = cont_reg;
  assign deep_power_down = pdn_reg;
  assign soft_reset      = soft_reset_reg;
  assign busy            = busy_reg;
  assign rd_addr         = rd_addr_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_pdn_cmd;
    frame_go && st_reg == ST_IDLE && !f.cont && f.op == OP_PDN &&
      f.cnt == CNT_OP;
  endsequence

  sequence s_pdn_reached;
    st_reg == ST_PDN_ENT ##[1:A_DP_MAX] st_reg == ST_PDN;
  endsequence

  sequence s_rel_cmd;
    frame_go && st_reg == ST_PDN && !f.cont && f.op == OP_REL &&
      f.cnt >= CNT_OP;
  endsequence

  chk_pdn_entry: assert property (
    s_pdn_cmd |=> s_pdn_reached)
    else $error("deep power-down not entered in time");

  chk_pdn_no_reset: assert property (
    frame_go && st_reg == ST_PDN |=> !soft_reset_reg && st_reg != ST_IDLE)
    else $error("command acted during deep power-down");

  chk_release_path: assert property (
    s_rel_cmd |=> st_reg == ST_REL ##[1:A_REL_MAX] st_reg == ST_IDLE)
    else $error("release from deep power-down failed");

  chk_rst_en_clear: assert property (
    frame_go && st_reg == ST_IDLE && (f.cont || f.op != OP_RST_EN)
      |=> !rst_en_reg)
    else $error("reset enable survived another command");

  chk_rst_hold_gate: assert property (
    frame_go && st_reg == ST_IDLE && !hold_ok |=> !soft_reset_reg)
    else $error("reset taken before hold delay");

  chk_rst_defaults: assert property (
    soft_reset_reg |-> wrap_field_reg == WRAP_DEFAULT && !cont_reg &&
      st_reg == ST_RST ##1 !soft_reset_reg)
    else $error("software reset state wrong");

  chk_wrap_load: assert property (
    frame_go && st_reg == ST_IDLE && !f.cont && f.op == OP_WRAP &&
      f.cnt >= CNT_WRAP_MIN |=> wrap_field_reg == $past(f_wrap))
    else $error("wrap field not loaded");

  chk_cont_skip: assert property (
    frame_go && st_reg == ST_IDLE && mode_done |=> cont_reg == $past(mode_skip))
    else $error("continuous mode not set from mode bits");

  chk_wrap_bound: assert property (
    ce && rd_next && !rd_load && rd_quad_io && wrap_field_reg == 3'h0
      |=> rd_addr_reg[ADDR_W-1:3] == $past(rd_addr_reg[ADDR_W-1:3]))
    else $error("wrapped read left its section");

endmodule : fmrc_top

/* src/fmrc_pkg.sv */
// Constants, types and carriers for the flash mode and reset control block.
// Assumes a 50 MHz core clock and an SPI host driving mode 0 or 3.
//
// Overview of operation
// - Wrap setting is opcode 77h, 24 dummy bits, 8 wrap bits, CS low.
// - Wrap bit 7 and wrap bits 3..0 are ignored.
// - Wrap setting loads the wrap bits into third status register bits 6..4.
// - Later quad I/O reads stay inside an aligned 8/16/32/64 byte section.
// - Wrap disable bit is 1 after power-on; writing it 1 leaves wrap mode.
// - Software reset reloads all volatile state with its defaults; here only wrap field and continuous read.
// - An operation cut by software reset is unstable; host repeats it.
// - Software reset ignored in deep power-down until release and its delay.
// - Reset is 66h then 99h, executed at CS rise; host waits recovery.
// - Reset only if CS rises at least the hold delay after opcode end.
// - Any command other than 99h after 66h cancels the reset enable.
// - Mode bits 5..4 equal 10 make the next frame an opcode-less read.
// - Reserved mode bits may be 0 or 1 without effect.
// - Continuous read exit sets mode bit 4, restoring normal decoding.
// - Deep power-down B9h needs CS rise after bit 8; entered within delay.
// - In deep power-down only the release command ABh is recognized.
// - Device always powers up in normal standby, not deep power-down.
// - Wrap bit 4 clear enables wrapping; bits 6..5 select the section length.
// - Wrapped reads start at the address and wrap at the section end.
package fmrc_pkg;

  localparam logic [7:0] OP_WRAP   = 8'h77;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST    = 8'h99;
  localparam logic [7:0] OP_PDN    = 8'hb9;
  localparam logic [7:0] OP_REL    = 8'hab;
  localparam logic [7:0] OP_QIO    = 8'heb;
  localparam logic [7:0] OP_DIO    = 8'hbb;

  // Bit positions inside a frame, counted in SCK edges
  localparam logic [5:0] CNT_OP       = 6'h08;
  localparam logic [5:0] CNT_WRAP_MIN = 6'h10;
  localparam logic [5:0] CNT_SAT      = 6'h3f;
  localparam logic [5:0] POS_QUAD     = 6'h06;
  localparam logic [5:0] POS_DUAL     = 6'h0d;

  localparam logic [2:0] WRAP_DEFAULT  = 3'h7;
  localparam logic [1:0] SKIP_CODE     = 2'h2;
  localparam int         WRAP_MIN_BYTES = 8;

  // Core clock in MHz, timing figures in ns
  localparam int CLK_MHZ   = 50;
  localparam int T_RCH_NS  = 50;
  localparam int T_DP_NS   = 3000;
  localparam int T_RES1_NS = 3000;
  localparam int T_RST_NS  = 30000;

  // Least times round up, the entry time is a longest time and rounds down
  localparam int T_RCH_CYC  = (T_RCH_NS * CLK_MHZ + 999) / 1000;
  localparam int T_DP_CYC   = (T_DP_NS * CLK_MHZ) / 1000;
  localparam int T_RES1_CYC = (T_RES1_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RST_CYC  = (T_RST_NS * CLK_MHZ + 999) / 1000;

  localparam int TMR_W  = 11;
  localparam int HOLD_W = 8;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_PDN_ENT = 5'h02,
    ST_PDN     = 5'h04,
    ST_REL     = 5'h08,
    ST_RST     = 5'h10
  } fmrc_state_t;

  // One frame as seen by the link side
  typedef struct packed {
    logic [7:0] op;
    logic [5:0] cnt;
    logic [2:0] wrap;
    logic [1:0] mode;
    logic       cont;
  } fmrc_frame_t;

endpackage : fmrc_pkg

/* src/fmrc_sync.sv */
// Two-flop level synchroniser, one stage pair per bit.
// Assumes each bit is an independent level or toggle.
module fmrc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = ce ? d : meta_reg;
    q_next    = ce ? meta_reg : q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule : fmrc_sync

/* src/fmrc_wrap_step.sv */
// Next read address with optional aligned wrap-around.
// Assumes the wrap field as held in the third status register.
module fmrc_wrap_step
  import fmrc_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [2:0]        wrap,
  input  wire logic              en,
  output logic      [ADDR_W-1:0] next_addr
);
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] inc;

  always_comb begin
    mask = ADDR_W'((WRAP_MIN_BYTES << wrap[2:1]) - 1);
    inc  = addr + 1'b1;
    if (en && !wrap[0]) begin
      next_addr = (addr & ~mask) | (inc & mask);
    end else begin
      next_addr = inc;
    end
  end
endmodule : fmrc_wrap_step

/* tb/fmrc_host.sv */
// Host SPI controller model: drives chip select, serial clock and IO lines.
// Assumes mode 0 timing, a 30 ns serial clock and a caller that sequences
// frames; the serial clock stands still between frames.
module fmrc_host (
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] io_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quad enable assumed already set by boot code
  initial begin
    sclk  = 1'b0;
    cs_n  = 1'b1;
    io_in = 4'h5;
  end

  // Data set while the clock is low, taken on the rise
  task automatic clk_nib(input logic [3:0] v);
    io_in = v;
    #15 sclk = 1'b1;
    #15 sclk = 1'b0;
  endtask : clk_nib

  task automatic begin_frame;
    cs_n = 1'b0;
    #15;
  endtask : begin_frame

  // Opcode MSB first on IO0; idle lines toggle so none looks driven
  task automatic op8(input logic [7:0] op);
    for (int i = 7; i >= 0; i--) begin
      clk_nib({{3{~op[i]}}, op[i]});
    end
  endtask : op8

  task automatic nibs(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      clk_nib(v[4*i+:4]);
    end
  endtask : nibs

  // Gap is the hold after the last bit; a short gap cancels a reset
  // Frames cut by a reset are repeated by the caller
  task automatic end_frame(input int gap);
    #(gap);
    cs_n  = 1'b1;
    io_in = ~io_in;
    #100;
  endtask : end_frame
endmodule : fmrc_host

/* tb/test_flash_mode_reset_control.sv */
// Self-checking bench for the mode and reset control block.
// Assumes the host model in fmrc_host; ce goes low only in its own test.
module test_flash_mode_reset_control;
  timeunit 1ns;
  timeprecision 100ps;
  import fmrc_pkg::*;

  logic        core_clk;
  logic        rstn;
  logic        ce;
  logic        sclk;
  logic        cs_n;
  logic [3:0]  io_in;
  logic        rd_load;
  logic [23:0] rd_load_addr;
  logic        rd_next;
  logic        rd_quad_io;
  logic [2:0]  wrap_field;
  logic        continuous_read;
  logic        deep_power_down;
  logic        soft_reset;
  logic        busy;
  logic [23:0] rd_addr;
  int          num_errors;
  int          n_checks;
  int          n_rst;
  int          r0;
  logic [7:0]  wb;
  logic [2:0]  wexp;

  fmrc_top #(.ADDR_W(24)) u_dut (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .sclk(sclk), .cs_n(cs_n),
    .io_in(io_in), .rd_load(rd_load), .rd_load_addr(rd_load_addr),
    .rd_next(rd_next), .rd_quad_io(rd_quad_io), .wrap_field(wrap_field),
    .continuous_read(continuous_read), .deep_power_down(deep_power_down),
    .soft_reset(soft_reset), .busy(busy), .rd_addr(rd_addr)
  );

  fmrc_host u_host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (soft_reset === 1'b1) n_rst++;
  end

  function automatic logic [23:0] next_exp(input logic [23:0] a,
                                           input logic [2:0] w,
                                           input logic q);
    logic [23:0] m;
    m = (24'h8 << w[2:1]) - 24'h1;
    if (q && !w[0]) return (a & ~m) | ((a + 24'h1) & m);
    return a + 24'h1;
  endfunction : next_exp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Sel 0 watches busy, sel 1 watches deep power-down
  task automatic wait_for(input int sel, input logic v, input int lim);
    logic s;
    for (int i = 0; i < lim; i++) begin
      @(posedge core_clk);
      #2;
      s = (sel == 0) ? busy : deep_power_down;
      if (s === v) return;
    end
    num_errors++;
    $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, v);
    report_and_stop();
  endtask : wait_for

  task automatic cmd8(input logic [7:0] op, input int gap);
    u_host.begin_frame();
    u_host.op8(op);
    u_host.end_frame(gap);
  endtask : cmd8

  task automatic set_wrap(input logic [7:0] w);
    u_host.begin_frame();
    u_host.op8(OP_WRAP);
    u_host.nibs(64'($urandom), 6);
    u_host.nibs({56'h0, w}, 2);
    u_host.end_frame(30);
  endtask : set_wrap

  // Quad: 6 address nibbles then mode; dual: 12 address clocks then 4 mode
  task automatic cont_frame(input logic dual, input logic with_op,
                            input logic [1:0] m54);
    u_host.begin_frame();
    if (with_op) u_host.op8(dual ? OP_DIO : OP_QIO);
    u_host.nibs(64'($urandom), dual ? 12 : 6);
    if (dual) u_host.nibs({48'h0, 4'($urandom), 2'($urandom), m54, 8'($urandom)}, 4);
    else u_host.nibs({56'h0, 2'($urandom), m54, 4'($urandom)}, 2);
    u_host.end_frame(30);
  endtask : cont_frame

  task automatic rd_run(input logic [2:0] w, input logic q, input int n);
    logic [23:0] a;
    a = 24'($urandom);
    @(posedge core_clk);
    #2;
    rd_quad_io = q;
    rd_load_addr = a;
    rd_load = 1'b1;
    @(posedge core_clk);
    #2;
    rd_load = 1'b0;
    rd_next = 1'b1;
    check(rd_addr, a);
    repeat (n) begin
      @(posedge core_clk);
      #2;
      a = next_exp(a, w, q);
      check(rd_addr, a);
    end
    rd_next = 1'b0;
  endtask : rd_run

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    rd_load = 1'b0;
    rd_next = 1'b0;
    rd_quad_io = 1'b0;
    rd_load_addr = 24'h0;
    num_errors = 0;
    n_checks = 0;
    n_rst = 0;
    void'($urandom(32'hc7e60463));
    repeat (12) @(posedge core_clk);
    #2;
    rstn = 1'b1;
    check(wrap_field, 3'h7);
    check(deep_power_down, 1'b0);
    check({busy, continuous_read, soft_reset}, 3'h0);
    // Host start-up order: exit first, then wrap off
    u_host.begin_frame();
    u_host.op8(8'hff);
    u_host.op8(8'hff);
    u_host.end_frame(30);
    wb = 8'h10 | 8'($urandom);
    set_wrap(wb);
    check(wrap_field, wb[6:4]);
    rd_run(wb[6:4], 1'b1, 20);
    $display("test startup done");
    for (int k = 0; k < 8; k++) begin
      wb = 8'($urandom);
      if (k < 4) wb[6:4] = {k[1:0], 1'b0};
      set_wrap(wb);
      wexp = wb[6:4];
      check(wrap_field, wexp);
      rd_run(wexp, 1'b1, 70);
      rd_run(wexp, 1'b0, 10);
    end
    $display("test wrap done");
    // Warm reset with continuous mode on must bring back the defaults
    cont_frame(1'b0, 1'b1, 2'h2);
    check(continuous_read, 1'b1);
    @(posedge core_clk);
    #2;
    rstn = 1'b0;
    repeat (3) @(posedge core_clk);
    #2;
    rstn = 1'b1;
    check({wrap_field, continuous_read}, 4'he);
    check({deep_power_down, busy, soft_reset}, 3'h0);
    // Clock enable low freezes the address sequencer
    ce = 1'b0;
    rd_load_addr = 24'($urandom);
    rd_load = 1'b1;
    repeat (4) @(posedge core_clk);
    #2;
    check(rd_addr, 24'h0);
    ce = 1'b1;
    @(posedge core_clk);
    #2;
    rd_load = 1'b0;
    check(rd_addr, rd_load_addr);
    $display("test warm reset done");
    for (int k = 0; k < 8; k++) begin
      cont_frame(k[2], 1'b1, k[1:0]);
      check(continuous_read, k[1:0] == 2'h2);
      if (k[1:0] == 2'h2) begin
        cont_frame(k[2], 1'b0, 2'h2);
        check(continuous_read, 1'b1);
        u_host.begin_frame();
        u_host.op8(8'hff);
        if (k[2]) u_host.op8(8'hff);
        u_host.end_frame(30);
        check(continuous_read, 1'b0);
      end
    end
    $display("test continuous done");
    r0 = n_rst;
    cmd8(OP_RST_EN, 100);
    set_wrap(8'h40);
    cmd8(OP_RST, 100);
    check(wrap_field, 3'h4);
    cmd8(OP_RST_EN, 100);
    cmd8(OP_RST, 0);
    check(n_rst, r0);
    cmd8(OP_RST_EN, 100);
    cmd8(OP_RST, 100);
    check(n_rst, r0 + 1);
    check({busy, wrap_field}, 4'hf);
    wait_for(0, 1'b0, 2000);
    $display("test reset done");
    u_host.begin_frame();
    u_host.op8(OP_PDN);
    u_host.nibs(64'h1, 1);
    u_host.end_frame(0);
    check({busy, deep_power_down}, 2'h0);
    cmd8(OP_PDN, 0);
    wait_for(1, 1'b1, 300);
    r0 = n_rst;
    cmd8(OP_RST_EN, 100);
    cmd8(OP_RST, 100);
    set_wrap(8'h00);
    check(n_rst, r0);
    check({deep_power_down, wrap_field}, 4'hf);
    cmd8(OP_REL, 0);
    wait_for(1, 1'b0, 20);
    wait_for(0, 1'b0, 400);
    cmd8(OP_RST_EN, 100);
    cmd8(OP_RST, 100);
    check(n_rst, r0 + 1);
    wait_for(0, 1'b0, 2000);
    $display("test power-down done");
    report_and_stop();
  end
endmodule : test_flash_mode_reset_control
